// *** inc/swc_pkg.sv ***
// Purpose: shared constants and types of the sleep / wake controller
// Assumes: AXI4-Lite register slave, 32-bit data, one clock
// Notes:   register offsets are byte addresses
`default_nettype none
package swc_pkg;
  // register byte offsets
  localparam logic [31:0] OFF_CTRL    = 32'h0000_0000;
  localparam logic [31:0] OFF_WDT_PER = 32'h0000_0004;
  localparam logic [31:0] OFF_STATUS  = 32'h0000_0008;
  localparam logic [31:0] OFF_WDT_CNT = 32'h0000_000C;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // widths
  localparam int          WDT_W       = 16;
  localparam int          IRQ_N       = 8;
  localparam int          PORT_N      = 8;
  localparam int          SYNC_N      = 4;
  // synchroniser lanes
  localparam int          SY_EXT      = 0;
  localparam int          SY_BOR      = 1;
  localparam int          SY_POR      = 2;
  localparam int          SY_LF       = 3;
  // second timer clock source codes
  localparam logic [1:0]  T2_SRC_CORE = 2'h0;
  localparam logic [1:0]  T2_SRC_LF   = 2'h1;
  localparam logic [1:0]  T2_SRC_PIN  = 2'h2;
  // watchdog reset values and count step
  localparam logic [WDT_W-1:0] WDT_PER_RST = 16'h0400;
  localparam logic [WDT_W-1:0] WDT_ZERO    = 16'h0000;
  localparam logic [WDT_W-1:0] WDT_ONE     = 16'h0001;

  // control register fields
  typedef struct packed {
    logic       adc_rc;
    logic [1:0] t2_src;
    logic       wdt_sleep_run;
    logic       wdt_en;
    logic       bor_en;
    logic       ext_rst_en;
  } swc_ctrl_t;

  localparam swc_ctrl_t CTRL_RST = '{adc_rc: 1'b0, t2_src: T2_SRC_CORE,
    wdt_sleep_run: 1'b1, wdt_en: 1'b0, bor_en: 1'b1, ext_rst_en: 1'b1};

  // cause of the last wake
  typedef enum logic [2:0] {
    WAKE_NONE, WAKE_EXT, WAKE_BOR, WAKE_POR, WAKE_WDT, WAKE_IRQ
  } swc_wake_t;

  // status register fields
  typedef struct packed {
    swc_wake_t cause;
    logic      asleep;
    logic      timeout_flag;
    logic      power_down_flag;
  } swc_status_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN, ST_SLEEP, ST_RESUME, ST_NEXT
  } swc_state_t;
endpackage : swc_pkg
`default_nettype wire

// *** design/swc_top.sv ***
// Purpose: power-down sequencer with watchdog and register slave
// Assumes: core pulses sleep_exec_i when it executes the sleep opcode
// Notes:   all outputs registered; pins pass a two-flop synchroniser
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
// Functional notes
// - sleep is entered only when the core executes the sleep instruction
// - entering sleep clears the watchdog; it may keep counting in sleep
// - entering sleep clears power-down flag and sets timeout flag
// - the core execution clock is stopped while asleep
// - the low-frequency oscillator keeps running during sleep
// - second timer runs in sleep when clocked from oscillator or pin
// - converter runs in sleep when clocked from its own rc oscillator
// - port pins hold their pre-sleep drive state while asleep
// - sleep changes no reset source except the watchdog
// - wake on reset pin, brownout, power-on, watchdog or enabled irq
// - pin, brownout and power-on wakes reset; others resume execution
// - the next instruction is prefetched while sleep executes
// - irq wake needs its own enable; global enable does not gate
// - after irq wake run next instruction, then vector if global enable
// - every wake clears the watchdog count
// - pending enabled irq makes sleep a no-op with flags unchanged
// - irq during or after sleep wakes at once, flags as on entry
module swc_top (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // axi4-lite write
  input  wire logic [31:0]              awaddr_i,
  input  wire logic                     awvalid_i,
  output logic                          awready_o,
  input  wire logic [31:0]              wdata_i,
  input  wire logic [3:0]               wstrb_i,
  input  wire logic                     wvalid_i,
  output logic                          wready_o,
  output logic [1:0]                    bresp_o,
  output logic                          bvalid_o,
  input  wire logic                     bready_i,
  // axi4-lite read
  input  wire logic [31:0]              araddr_i,
  input  wire logic                     arvalid_i,
  output logic                          arready_o,
  output logic [31:0]                   rdata_o,
  output logic [1:0]                    rresp_o,
  output logic                          rvalid_o,
  input  wire logic                     rready_i,
  // core side
  input  wire logic                     sleep_exec_i,
  input  wire logic                     instr_retired_i,
  input  wire logic                     global_irq_enable_i,
  input  wire logic [swc_pkg::IRQ_N-1:0] irq_flag_i,
  input  wire logic [swc_pkg::IRQ_N-1:0] irq_enable_i,
  input  wire logic [swc_pkg::PORT_N-1:0] core_port_out_i,
  input  wire logic [swc_pkg::PORT_N-1:0] core_port_oe_i,
  output logic                          core_clk_en_o,
  output logic                          prefetch_o,
  output logic                          resume_o,
  output logic                          vector_isr_o,
  // pins and oscillators
  input  wire logic                     external_reset_pin_n_i,
  input  wire logic                     brownout_reset_i,
  input  wire logic                     power_on_reset_i,
  input  wire logic                     low_freq_internal_osc_i,
  output logic                          device_reset_o,
  output logic [swc_pkg::PORT_N-1:0]    port_out_o,
  output logic [swc_pkg::PORT_N-1:0]    port_oe_o,
  // peripheral run enables
  output logic                          low_freq_osc_en_o,
  output logic                          second_timer_run_o,
  output logic                          adc_run_o
);

  // exact-address match
  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [31:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  // state
  swc_pkg::swc_state_t        state_q, state_d;
  swc_pkg::swc_ctrl_t         ctrl_q, ctrl_d;
  swc_pkg::swc_wake_t         cause_q, cause_d;
  logic [swc_pkg::WDT_W-1:0]  wdt_per_q, wdt_per_d;
  logic [swc_pkg::WDT_W-1:0]  watchdog_counter_q, watchdog_counter_d;
  logic                       power_down_flag_q, power_down_flag_d;
  logic                       timeout_flag_q, timeout_flag_d;
  logic [swc_pkg::SYNC_N-1:0] sync1_q, sync2_q, sync_raw;
  logic                       lf_prev_q;
  logic                       awready_q, wready_q, bvalid_q, arready_q;
  logic                       rvalid_q;
  logic [1:0]                 bresp_q, rresp_q;
  logic [31:0]                rdata_q, awaddr_q, wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       clk_en_q, prefetch_q, resume_q, vector_q;
  logic                       dev_rst_q, lf_en_q, t2_run_q, adc_run_q;
  logic [swc_pkg::PORT_N-1:0] port_out_q, port_oe_q;

  // pin lanes, active high before the synchroniser
  assign sync_raw = {low_freq_internal_osc_i, power_on_reset_i,
                     brownout_reset_i, ~external_reset_pin_n_i};

  // reset sources and wake decode
  wire lf_tick  = sync2_q[swc_pkg::SY_LF] & ~lf_prev_q;
  wire rst_ext  = sync2_q[swc_pkg::SY_EXT] & ctrl_q.ext_rst_en;
  wire rst_bor  = sync2_q[swc_pkg::SY_BOR] & ctrl_q.bor_en;
  wire rst_por  = sync2_q[swc_pkg::SY_POR];
  wire full_rst = rst_ext | rst_bor | rst_por;
  wire asleep   = (state_q == swc_pkg::ST_SLEEP);
  wire pending  = |(irq_flag_i & irq_enable_i);
  wire sleep_go = sleep_exec_i & (state_q == swc_pkg::ST_RUN)
                  & ~pending & ~full_rst;
  wire wdt_run  = ctrl_q.wdt_en & (~asleep | ctrl_q.wdt_sleep_run);
  wire wdt_hit  = wdt_run & lf_tick & (watchdog_counter_q >= wdt_per_q);
  wire wake_irq = asleep & pending & ~full_rst;
  wire wake_wdt = asleep & wdt_hit & ~full_rst;
  wire wdt_rst  = wdt_hit & ~asleep;
  wire wdt_clr  = sleep_go | wake_irq | wake_wdt | wdt_hit | full_rst;

  // watchdog count
  assign watchdog_counter_d =
    wdt_clr ? swc_pkg::WDT_ZERO :
    (wdt_run & lf_tick) ? watchdog_counter_q + swc_pkg::WDT_ONE
                        : watchdog_counter_q;

  // status flags
  assign power_down_flag_d = full_rst ? 1'b1 :
                             sleep_go ? 1'b0 : power_down_flag_q;
  assign timeout_flag_d = full_rst ? 1'b1 :
                          sleep_go ? 1'b1 :
                          wdt_rst  ? 1'b0 : timeout_flag_q;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      swc_pkg::ST_RUN:    if (sleep_go) state_d = swc_pkg::ST_SLEEP;
      swc_pkg::ST_SLEEP:  if (wake_irq | wake_wdt) begin
        state_d = swc_pkg::ST_RESUME;
      end
      swc_pkg::ST_RESUME: state_d = swc_pkg::ST_NEXT;
      swc_pkg::ST_NEXT:   if (instr_retired_i) state_d = swc_pkg::ST_RUN;
    endcase
    if (full_rst) state_d = swc_pkg::ST_RUN;
  end

  // wake cause
  assign cause_d = rst_ext  ? swc_pkg::WAKE_EXT :
                   rst_bor  ? swc_pkg::WAKE_BOR :
                   rst_por  ? swc_pkg::WAKE_POR :
                   wake_irq ? swc_pkg::WAKE_IRQ :
                   wake_wdt ? swc_pkg::WAKE_WDT : cause_q;

  // register slave decode
  wire aw_take  = awvalid_i & awready_q;
  wire w_take   = wvalid_i & wready_q;
  wire wr_do    = ~awready_q & ~wready_q & ~bvalid_q;
  wire wr_ctrl  = wr_do & addr_is(awaddr_q, swc_pkg::OFF_CTRL);
  wire wr_per   = wr_do & addr_is(awaddr_q, swc_pkg::OFF_WDT_PER);
  wire wr_hit   = addr_is(awaddr_q, swc_pkg::OFF_CTRL)
                | addr_is(awaddr_q, swc_pkg::OFF_WDT_PER);
  wire ar_take  = arvalid_i & arready_q;
  wire rd_hit   = addr_is(araddr_i, swc_pkg::OFF_CTRL)
                | addr_is(araddr_i, swc_pkg::OFF_WDT_PER)
                | addr_is(araddr_i, swc_pkg::OFF_STATUS)
                | addr_is(araddr_i, swc_pkg::OFF_WDT_CNT);
  wire swc_pkg::swc_status_t status = '{cause: cause_q, asleep: asleep,
    timeout_flag: timeout_flag_q, power_down_flag: power_down_flag_q};
  wire [31:0] rd_data =
    addr_is(araddr_i, swc_pkg::OFF_CTRL)    ? 32'(ctrl_q) :
    addr_is(araddr_i, swc_pkg::OFF_WDT_PER) ? 32'(wdt_per_q) :
    addr_is(araddr_i, swc_pkg::OFF_STATUS)  ? 32'(status) :
    addr_is(araddr_i, swc_pkg::OFF_WDT_CNT) ? 32'(watchdog_counter_q)
                                            : 32'h0000_0000;

  // register writes honour byte lanes
  assign ctrl_d = (wr_ctrl & wstrb_q[0])
                ? swc_pkg::swc_ctrl_t'(wdata_q[$bits(swc_pkg::swc_ctrl_t)-1:0])
                : ctrl_q;
  assign wdt_per_d[7:0]  = (wr_per & wstrb_q[0]) ? wdata_q[7:0]
                                                 : wdt_per_q[7:0];
  assign wdt_per_d[15:8] = (wr_per & wstrb_q[1]) ? wdata_q[15:8]
                                                 : wdt_per_q[15:8];

  // pin synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    sync1_q   <= sync_raw;
    sync2_q   <= sync1_q;
    lf_prev_q <= sync2_q[swc_pkg::SY_LF];
  end

  // core state registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q            <= swc_pkg::ST_RUN;
      ctrl_q             <= swc_pkg::CTRL_RST;
      cause_q            <= swc_pkg::WAKE_NONE;
      wdt_per_q          <= swc_pkg::WDT_PER_RST;
      watchdog_counter_q <= swc_pkg::WDT_ZERO;
      power_down_flag_q  <= 1'b1;
      timeout_flag_q     <= 1'b1;
    end else begin
      state_q            <= state_d;
      ctrl_q             <= ctrl_d;
      cause_q            <= cause_d;
      wdt_per_q          <= wdt_per_d;
      watchdog_counter_q <= watchdog_counter_d;
      power_down_flag_q  <= power_down_flag_d;
      timeout_flag_q     <= timeout_flag_d;
    end
  end

  // axi write channel
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= swc_pkg::RESP_OKAY;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_take) awready_q <= 1'b0;
      if (aw_take) awaddr_q <= awaddr_i;
      if (w_take) wready_q <= 1'b0;
      if (w_take) wdata_q <= wdata_i;
      if (w_take) wstrb_q <= wstrb_i;
      if (wr_do) bvalid_q <= 1'b1;
      if (wr_do) bresp_q <= wr_hit ? swc_pkg::RESP_OKAY
                                   : swc_pkg::RESP_SLVERR;
      if (bvalid_q & bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // axi read channel
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= swc_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_hit ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end else if (rvalid_q & rready_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // core, pin and peripheral outputs
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      clk_en_q   <= 1'b1;
      prefetch_q <= 1'b0;
      resume_q   <= 1'b0;
      vector_q   <= 1'b0;
      dev_rst_q  <= 1'b0;
      lf_en_q    <= 1'b0;
      t2_run_q   <= 1'b1;
      adc_run_q  <= 1'b1;
      port_out_q <= '0;
      port_oe_q  <= '0;
    end else begin
      clk_en_q   <= (state_d != swc_pkg::ST_SLEEP);
      prefetch_q <= sleep_go;
      resume_q   <= (state_d == swc_pkg::ST_RESUME);
      vector_q   <= (state_q == swc_pkg::ST_NEXT) & instr_retired_i
                    & global_irq_enable_i & ~full_rst
                    & (cause_q == swc_pkg::WAKE_IRQ);
      dev_rst_q  <= full_rst | wdt_rst;
      lf_en_q    <= 1'b1;
      t2_run_q   <= ~asleep | (ctrl_q.t2_src == swc_pkg::T2_SRC_LF)
                    | (ctrl_q.t2_src == swc_pkg::T2_SRC_PIN);
      adc_run_q  <= ~asleep | ctrl_q.adc_rc;
      if (!asleep) begin
        port_out_q <= core_port_out_i;
        port_oe_q  <= core_port_oe_i;
      end
    end
  end

  // output ports
  assign awready_o          = awready_q;
  assign wready_o           = wready_q;
  assign bvalid_o           = bvalid_q;
  assign bresp_o            = bresp_q;
  assign arready_o          = arready_q;
  assign rvalid_o           = rvalid_q;
  assign rresp_o            = rresp_q;
  assign rdata_o            = rdata_q;
  assign core_clk_en_o      = clk_en_q;
  assign prefetch_o         = prefetch_q;
  assign resume_o           = resume_q;
  assign vector_isr_o       = vector_q;
  assign device_reset_o     = dev_rst_q;
  assign low_freq_osc_en_o  = lf_en_q;
  assign second_timer_run_o = t2_run_q;
  assign adc_run_o          = adc_run_q;
  assign port_out_o         = port_out_q;
  assign port_oe_o          = port_oe_q;

  // checks
  sleep_entry_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (asleep && $past(state_q) != swc_pkg::ST_SLEEP) |-> $past(sleep_exec_i))
    else $error("sleep entered without sleep instruction");
  wdt_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (sleep_go || wake_irq || wake_wdt) |=> watchdog_counter_q == '0)
    else $error("watchdog not cleared at sleep entry or wake");
  sleep_flags_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sleep_go |=> (!power_down_flag_q && timeout_flag_q && asleep))
    else $error("flags wrong after sleep entry");
  clk_stop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    asleep |-> !core_clk_en_o)
    else $error("core clock running while asleep");
  timer_run_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (asleep && ctrl_q.t2_src != swc_pkg::T2_SRC_CORE) |=> second_timer_run_o)
    else $error("second timer stopped in sleep");
  port_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    asleep |=> ($stable(port_out_o) && $stable(port_oe_o)))
    else $error("port drive changed while asleep");
  reset_wake_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    full_rst |=> (state_q == swc_pkg::ST_RUN && device_reset_o))
    else $error("reset source did not reset");
  prefetch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sleep_go |=> prefetch_o ##1 !prefetch_o)
    else $error("prefetch pulse missing");
  sleep_nop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (sleep_exec_i && pending && state_q == swc_pkg::ST_RUN && !full_rst
     && !wdt_hit) |=> ($stable(power_down_flag_q) && $stable(timeout_flag_q)
     && state_q == swc_pkg::ST_RUN))
    else $error("sleep not a no-op with pending irq");
  irq_wake_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_irq |=> (state_q == swc_pkg::ST_RESUME && core_clk_en_o && resume_o)
    ##1 state_q == swc_pkg::ST_NEXT)
    else $error("irq wake not immediate");
  vector_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    vector_isr_o |-> ($past(instr_retired_i) && $past(global_irq_enable_i)))
    else $error("vector without retired instruction");

endmodule : swc_top
`default_nettype wire

// *** test/swc_core_model.sv ***
// Purpose: core-side partner that issues sleep and retires instructions
// Assumes: the core only acts while its clock enable is high
// Notes:   scramble_i moves the pin drive even while the core is halted
`default_nettype none
module swc_core_model (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  // bench commands
  input  wire logic                       req_sleep_i,
  input  wire logic                       scramble_i,
  input  wire logic [3:0]                 ret_delay_i,
  // design side
  input  wire logic                       core_clk_en_i,
  input  wire logic                       resume_i,
  output logic                            sleep_exec_o,
  output logic                            instr_retired_o,
  output logic [swc_pkg::PORT_N-1:0]      port_out_o,
  output logic [swc_pkg::PORT_N-1:0]      port_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic       busy_q;
  logic [7:0] cnt_q;

  // sleep issue, retire after resume, moving pin pattern
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sleep_exec_o    <= 1'b0;
      instr_retired_o <= 1'b0;
      busy_q          <= 1'b0;
      wait_q          <= 4'h0;
      cnt_q           <= 8'h00;
    end else begin
      sleep_exec_o    <= req_sleep_i && core_clk_en_i;
      instr_retired_o <= busy_q && (wait_q == 4'h0);
      if (resume_i) begin
        busy_q <= 1'b1;
        wait_q <= ret_delay_i;
      end else if (busy_q && (wait_q == 4'h0)) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
      if (core_clk_en_i || scramble_i) cnt_q <= cnt_q + 8'h01;
    end
  end

  // drive pattern follows the counter
  assign port_out_o = cnt_q;
  assign port_oe_o  = ~cnt_q;
endmodule : swc_core_model
`default_nettype wire

// *** test/tb_swc_top.sv ***
// Purpose: self-checking bench for the sleep / wake controller
// Assumes: core partner model drives sleep and retire strobes
// Notes:   watchdog ticks come from a slow oscillator toggled here
`default_nettype none
module tb_swc_top;
  timeunit 1ns;
  timeprecision 1ps;
  // bench signals
  logic        clk_i = 1'b0;
  logic        resetn_i;
  logic [31:0] awaddr_i, wdata_i, araddr_i, rdata_o;
  logic [3:0]  wstrb_i, ret_delay;
  logic [1:0]  bresp_o, rresp_o;
  logic        awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
  logic        arvalid_i, arready_o, rvalid_o, rready_i;
  logic        sleep_exec_i, instr_retired_i, global_irq_enable_i;
  logic [7:0]  irq_flag_i, irq_enable_i, core_port_out_i, core_port_oe_i;
  logic [7:0]  port_out_o, port_oe_o;
  logic [15:0] pins_q;
  logic        core_clk_en_o, prefetch_o, resume_o, vector_isr_o;
  logic        external_reset_pin_n_i, brownout_reset_i, power_on_reset_i;
  logic        low_freq_internal_osc_i, device_reset_o, low_freq_osc_en_o;
  logic        second_timer_run_o, adc_run_o, req_sleep, scramble;
  int          fail_count = 0;
  int          total_checks = 0;
  int          n_res = 0, n_vec = 0, n_rst = 0;

  // design and core partner
  swc_top swc_top_i (
    .clk_i, .resetn_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
    .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
    .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
    .rready_i, .sleep_exec_i, .instr_retired_i, .global_irq_enable_i,
    .irq_flag_i, .irq_enable_i, .core_port_out_i, .core_port_oe_i,
    .core_clk_en_o, .prefetch_o, .resume_o, .vector_isr_o,
    .external_reset_pin_n_i, .brownout_reset_i, .power_on_reset_i,
    .low_freq_internal_osc_i, .device_reset_o, .port_out_o,
    .port_oe_o, .low_freq_osc_en_o, .second_timer_run_o, .adc_run_o);
  swc_core_model swc_core_model_i (
    .clk_i, .resetn_i, .req_sleep_i(req_sleep),
    .scramble_i(scramble), .ret_delay_i(ret_delay),
    .core_clk_en_i(core_clk_en_o), .resume_i(resume_o),
    .sleep_exec_o(sleep_exec_i), .instr_retired_o(instr_retired_i),
    .port_out_o(core_port_out_i), .port_oe_o(core_port_oe_i));

  // clock and output pulse tallies
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (resume_o === 1'b1) n_res <= n_res + 1;
    if (vector_isr_o === 1'b1) n_vec <= n_vec + 1;
    if (device_reset_o === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_up(input string nm);
    fail_count++;
    $display("[ERR] %s expected answer seen timeout", nm);
    final_report();
  endtask : give_up

  // bus write with both channels offered together
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
    int k;
    @(posedge clk_i);
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_i);
      if (awvalid_i && awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o === 1'b1) wvalid_i <= 1'b0;
      if (bvalid_o === 1'b1) break;
    end
    if (k == 40) give_up("bvalid");
    check("bresp", {30'h0, bresp_o}, {30'h0, er});
    bready_i <= 1'b0;
  endtask : axi_wr

  // bus read, masked compare of data and response
  task automatic rd_chk(input string nm, input logic [31:0] a, m, e,
                        input logic [1:0] er);
    int k;
    @(posedge clk_i);
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_i);
      if (arvalid_i && arready_o === 1'b1) arvalid_i <= 1'b0;
      if (rvalid_o === 1'b1) break;
    end
    if (k == 40) give_up("rvalid");
    check(nm, rdata_o & m, e);
    check("rresp", {30'h0, rresp_o}, {30'h0, er});
    rready_i <= 1'b0;
  endtask : rd_chk

  // core executes the sleep opcode; pins captured at the taking edge
  task automatic go_sleep;
    @(posedge clk_i);
    req_sleep <= 1'b1;
    @(posedge clk_i);
    req_sleep <= 1'b0;
    @(posedge clk_i);
    pins_q = {core_port_out_i, core_port_oe_i};
    #1;
  endtask : go_sleep

  // one slow oscillator period
  task automatic tick;
    @(posedge clk_i);
    low_freq_internal_osc_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    low_freq_internal_osc_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : tick

  task automatic s_reset;
    @(posedge clk_i);
    #1;
    check("clk_en", core_clk_en_o, 1);
    check("lf_en", low_freq_osc_en_o, 1);
    rd_chk("ctrl", swc_pkg::OFF_CTRL, 32'h7F, 32'h0B, 2'h0);
    rd_chk("per", swc_pkg::OFF_WDT_PER, 32'hFFFF, 32'h0400, 2'h0);
    rd_chk("stat", swc_pkg::OFF_STATUS, 32'h7, 32'h3, 2'h0);
    rd_chk("hole", 32'h10, 32'hFFFF_FFFF, 32'h0, swc_pkg::RESP_SLVERR);
    axi_wr(swc_pkg::OFF_STATUS, 32'h0, swc_pkg::RESP_SLVERR);
    rd_chk("stat_ro", swc_pkg::OFF_STATUS, 32'h7, 32'h3, 2'h0);
    axi_wr(swc_pkg::OFF_WDT_PER, 32'h1234, 2'h0);
    rd_chk("per_rw", swc_pkg::OFF_WDT_PER, 32'hFFFF, 32'h1234, 2'h0);
  endtask : s_reset

  task automatic s_noop;
    irq_enable_i <= 8'h01;
    irq_flag_i   <= 8'h01;
    ret_delay    <= 4'hF;
    go_sleep();
    check("noop_clk", core_clk_en_o, 1);
    rd_chk("noop_st", swc_pkg::OFF_STATUS, 32'h7, 32'h3, 2'h0);
    irq_flag_i <= 8'h00;
    go_sleep();
    check("clk_off", core_clk_en_o, 0);
    check("prefetch", prefetch_o, 1);
    @(posedge clk_i);
    irq_flag_i <= 8'h02;
    repeat (4) @(posedge clk_i);
    #1;
    check("masked", core_clk_en_o, 0);
    @(posedge clk_i);
    irq_flag_i <= 8'h03;
    @(posedge clk_i);
    #1;
    check("wake_clk", core_clk_en_o, 1);
    check("resume", resume_o, 1);
    repeat (25) @(posedge clk_i);
    check("no_vec", n_vec, 0);
    rd_chk("irq_st", swc_pkg::OFF_STATUS, 32'h3F, 32'h2A, 2'h0);
    irq_flag_i <= 8'h00;
  endtask : s_noop

  task automatic s_irq;
    int v;
    axi_wr(swc_pkg::OFF_CTRL, 32'h5B, 2'h0);
    irq_enable_i        <= 8'h04;
    global_irq_enable_i <= 1'b1;
    ret_delay           <= 4'h0;
    v = n_vec;
    go_sleep();
    scramble <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check("pins", {port_out_o, port_oe_o}, pins_q);
    check("t2_run", second_timer_run_o, 1);
    check("adc_run", adc_run_o, 1);
    check("lf_run", low_freq_osc_en_o, 1);
    rd_chk("slp_st", swc_pkg::OFF_STATUS, 32'h7, 32'h6, 2'h0);
    scramble   <= 1'b0;
    irq_flag_i <= 8'h04;
    @(posedge clk_i);
    #1;
    check("resume", resume_o, 1);
    repeat (25) @(posedge clk_i);
    check("vector", n_vec - v, 1);
    check("no_rst", n_rst, 0);
    irq_flag_i <= 8'h00;
  endtask : s_irq

  task automatic s_wdt;
    int k;
    int r;
    axi_wr(swc_pkg::OFF_WDT_PER, 32'h4, 2'h0);
    axi_wr(swc_pkg::OFF_CTRL, 32'h0F, 2'h0);
    repeat (3) tick();
    rd_chk("cnt_up", swc_pkg::OFF_WDT_CNT, 32'hFFFF, 32'h3, 2'h0);
    go_sleep();
    rd_chk("cnt_clr", swc_pkg::OFF_WDT_CNT, 32'hFFFF, 32'h0, 2'h0);
    check("t2_stop", second_timer_run_o, 0);
    check("adc_stop", adc_run_o, 0);
    r = n_res;
    for (k = 0; k < 12 && n_res == r; k++) tick();
    check("wdt_wake", n_res - r, 1);
    repeat (25) @(posedge clk_i);
    check("wdt_novec", n_vec, 1);
    check("wdt_norst", n_rst, 0);
    rd_chk("cnt_wake", swc_pkg::OFF_WDT_CNT, 32'hFFFF, 32'h0, 2'h0);
    rd_chk("wdt_st", swc_pkg::OFF_STATUS, 32'h3F, 32'h22, 2'h0);
    axi_wr(swc_pkg::OFF_CTRL, 32'h0B, 2'h0);
  endtask : s_wdt

  task automatic s_rst;
    int k;
    int r;
    int q;
    for (k = 0; k < 4; k++) begin
      if (k == 3) axi_wr(swc_pkg::OFF_CTRL, 32'h28, 2'h0);
      go_sleep();
      @(posedge clk_i);
      r = n_rst;
      q = n_res;
      external_reset_pin_n_i <= !(k == 0 || k == 3);
      brownout_reset_i       <= (k == 1 || k == 3);
      power_on_reset_i       <= (k == 2);
      repeat (6) @(posedge clk_i);
      external_reset_pin_n_i <= 1'b1;
      brownout_reset_i       <= 1'b0;
      power_on_reset_i       <= 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      check("rst_seen", n_rst != r, k != 3);
      check("rst_nores", n_res - q, 0);
      check("t2_pin", second_timer_run_o, 1);
      if (k < 3) begin
        rd_chk("rst_st", swc_pkg::OFF_STATUS, 32'h3F, 32'((k + 1) * 8 + 3),
               2'h0);
      end
    end
  endtask : s_rst

  // time-zero values, reset, scenarios
  initial begin
    resetn_i = 1'b0;
    {awaddr_i, wdata_i, araddr_i} = '0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    wstrb_i = 4'hF;
    {global_irq_enable_i, irq_flag_i, irq_enable_i} = '0;
    {brownout_reset_i, power_on_reset_i, low_freq_internal_osc_i} = '0;
    external_reset_pin_n_i = 1'b1;
    {req_sleep, scramble, ret_delay} = '0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    s_reset();
    s_noop();
    s_irq();
    s_wdt();
    s_rst();
    final_report();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    give_up("run");
  end
endmodule : tb_swc_top
`default_nettype wire
